/* hdl/pbu_admission.sv */
// APB register file and admission control of the packet buffer unit
`timescale 1ns/100ps
module pbu_admission #(
   parameter int AW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [pbu_pkg::DATA_W-1:0] pwdata,
   output logic [pbu_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [pbu_pkg::NPORT-1:0] buf_alloc,
   input wire logic [pbu_pkg::NPORT-1:0] buf_free,
   input wire logic [pbu_pkg::NPORT-1:0] pkt_req,
   input wire logic [pbu_pkg::NPORT-1:0] pkt_red,
   input wire logic [pbu_pkg::NPORT-1:0] pkt_yel_hit,
   output logic [pbu_pkg::NPORT-1:0] pkt_drop,
   output logic [pbu_pkg::NPORT-1:0] pause_frame,
   output logic [pbu_pkg::NPORT-1:0] resume_frame,
   output logic [pbu_pkg::NPORT-1:0] port_paused,
   output logic fixed_prio_sel,
   output logic [pbu_pkg::NPORT-1:0] egress_pace_en,
   output logic yellow_discard_en,
   output logic red_discard_en,
   output logic cnt_test_mode
);
   import pbu_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [CFG_W-1:0] cfg;
      logic [LVL_REG_W-1:0] drop;
      logic [LVL_REG_W-1:0] pause;
      logic [LVL_REG_W-1:0] resume;
      logic [DATA_W-1:0] rdata;
      logic ready;
      logic slverr;
   } pbu_top_st_t;

   pbu_top_st_t st_r;
   pbu_top_st_t st_nxt;

   logic [NPORT-1:0] act;
   logic [1:0] n_act;
   logic multi;
   logic [LVL_W-1:0] drop_sel;
   logic [LVL_W-1:0] pause_sel;
   logic [LVL_W-1:0] resume_sel;
   logic [NPORT-1:0] cnt_clr;
   logic [DATA_W-1:0] cnt_val [NPORT];
   logic rd_cap;
   logic wr_done;
   pbu_sel_t sel;

   // Refused at elaboration: the map needs the full index plus byte bits
   if (AW < IDX_W + 2) begin : g_bad_aw
      $error("pbu_admission: AW too narrow for register map");
   end

   // ==========================================================
   // Decoding helpers
   function automatic pbu_sel_t reg_decode(input logic [AW-1:0] a);
      logic [AW-1:0] w;
      w = a >> 2;
      reg_decode = SEL_NONE;
      if (a[1:0] == 2'b00) begin
         if (w == AW'(IDX_CFG)) begin
            reg_decode = SEL_CFG;
         end else if (w == AW'(IDX_DROP)) begin
            reg_decode = SEL_DROP;
         end else if (w == AW'(IDX_PAUSE)) begin
            reg_decode = SEL_PAUSE;
         end else if (w == AW'(IDX_RESUME)) begin
            reg_decode = SEL_RESUME;
         end else if (w == AW'(IDX_STAT)) begin
            reg_decode = SEL_STAT;
         end
      end
   endfunction : reg_decode

   function automatic logic cnt_hit(input logic [AW-1:0] a, input int p);
      logic [AW-1:0] w;
      w = a >> 2;
      cnt_hit = (a[1:0] == 2'b00) && (w == AW'(IDX_CNT_BASE) + AW'(p));
   endfunction : cnt_hit

   // Pick the multi-port or single-port byte of a level register
   function automatic logic [LVL_W-1:0] lvl_pick(input logic [LVL_REG_W-1:0] v,
                                                 input logic m);
      lvl_pick = m ? v[LVL_MULTI_LSB +: LVL_W] : v[LVL_SINGLE_LSB +: LVL_W];
   endfunction : lvl_pick

   // ==========================================================
   // Active port count and threshold selection
   always_comb begin
      n_act = 2'b00;
      for (int p = 0; p < NPORT; p++) begin
         n_act = n_act + {1'b0, act[p]};
      end
   end

   // No active port uses the single-port set, as one active would
   assign multi = n_act >= 2'(MULTI_PORTS);
   assign drop_sel = lvl_pick(st_r.drop, multi);
   assign pause_sel = lvl_pick(st_r.pause, multi);
   assign resume_sel = lvl_pick(st_r.resume, multi);

   // ==========================================================
   // Per-port trackers and drop counters
   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_port
         pbu_port_track #(
            .UW(USE_W)
         ) u_track (
            .pclk(pclk),
            .presetn(presetn),
            .buf_alloc(buf_alloc[gp]),
            .buf_free(buf_free[gp]),
            .pkt_req(pkt_req[gp]),
            .pkt_red(pkt_red[gp]),
            .pkt_yel_hit(pkt_yel_hit[gp]),
            .red_en(st_r.cfg[CFG_RED_BIT]),
            .yel_en(st_r.cfg[CFG_YEL_BIT]),
            .drop_lvl(drop_sel),
            .pause_lvl(pause_sel),
            .resume_lvl(resume_sel),
            .active(act[gp]),
            .paused(port_paused[gp]),
            .pause_frame(pause_frame[gp]),
            .resume_frame(resume_frame[gp]),
            .pkt_drop(pkt_drop[gp])
         );

         // Clear at capture so a drop in the same cycle is kept
         assign cnt_clr[gp] = rd_cap && cnt_hit(paddr, gp);

         pbu_drop_cnt #(
            .CW(DATA_W)
         ) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .inc(pkt_drop[gp]),
            .rd_clr(cnt_clr[gp]),
            .test_mode(st_r.cfg[CFG_TEST_BIT]),
            .count(cnt_val[gp])
         );
      end
   endgenerate

   // ==========================================================
   // APB slave
   // Setup cycle captures read data and raises pready, so every
   // transfer has exactly one access cycle
   assign rd_cap = psel && !penable && !pwrite;
   assign wr_done = psel && penable && st_r.ready && pwrite;
   assign sel = reg_decode(paddr);

   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = psel && !penable;
      st_nxt.slverr = 1'b0;
      if (psel && !penable) begin
         st_nxt.rdata = '0;
         st_nxt.slverr = 1'b1;
         if (sel != SEL_NONE) begin
            st_nxt.slverr = 1'b0;
         end
         case (sel)
            SEL_CFG: begin
               st_nxt.rdata = DATA_W'(st_r.cfg);
            end
            SEL_DROP: begin
               st_nxt.rdata = DATA_W'(st_r.drop);
            end
            SEL_PAUSE: begin
               st_nxt.rdata = DATA_W'(st_r.pause);
            end
            SEL_RESUME: begin
               st_nxt.rdata = DATA_W'(st_r.resume);
            end
            SEL_STAT: begin
               st_nxt.rdata[STAT_ACT_LSB +: NPORT] = act;
               st_nxt.rdata[STAT_PAUSED_LSB +: NPORT] = port_paused;
               st_nxt.rdata[STAT_MULTI_BIT] = multi;
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
         for (int p = 0; p < NPORT; p++) begin
            if (cnt_hit(paddr, p)) begin
               st_nxt.rdata = pwrite ? '0 : cnt_val[p];
               st_nxt.slverr = 1'b0;
            end
         end
      end
      // Writes land at the completing edge; read-only words ignore them
      if (wr_done) begin
         case (sel)
            SEL_CFG: begin
               st_nxt.cfg = pwdata[CFG_W-1:0];
            end
            SEL_DROP: begin
               st_nxt.drop = pwdata[LVL_REG_W-1:0];
            end
            SEL_PAUSE: begin
               st_nxt.pause = pwdata[LVL_REG_W-1:0];
            end
            SEL_RESUME: begin
               st_nxt.resume = pwdata[LVL_REG_W-1:0];
            end
            default: begin
               st_nxt.cfg = st_r.cfg;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.cfg <= CFG_RST;
         st_r.drop <= DROP_RST;
         st_r.pause <= PAUSE_RST;
         st_r.resume <= RESUME_RST;
         st_r.rdata <= '0;
         st_r.ready <= 1'b0;
         st_r.slverr <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs straight from the register file
   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.slverr;
   assign fixed_prio_sel = st_r.cfg[CFG_FIXPRIO_BIT];
   assign egress_pace_en = st_r.cfg[CFG_PACE_LSB +: NPORT];
   assign yellow_discard_en = st_r.cfg[CFG_YEL_BIT];
   assign red_discard_en = st_r.cfg[CFG_RED_BIT];
   assign cnt_test_mode = st_r.cfg[CFG_TEST_BIT];

   // ==========================================================
   // Checks
   logic w_fix;
   logic [NPORT-1:0] w_pace;
   assign w_fix = pwdata[CFG_FIXPRIO_BIT];
   assign w_pace = pwdata[CFG_PACE_LSB +: NPORT];

   sequence s_cfg_write;
      wr_done && sel == SEL_CFG;
   endsequence

   a_apb_answer: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");

   a_prio_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_cfg_write |=> fixed_prio_sel == $past(w_fix))
      else $error("queue order bit not written");

   a_pace_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_cfg_write |=> egress_pace_en == $past(w_pace))
      else $error("pacing enables not written");

   a_multi_levels: assert property (
      @(posedge pclk) disable iff (!presetn)
      n_act >= 2'(MULTI_PORTS) |-> drop_sel == st_r.drop[LVL_MULTI_LSB +: LVL_W]
         && pause_sel == st_r.pause[LVL_MULTI_LSB +: LVL_W]
         && resume_sel == st_r.resume[LVL_MULTI_LSB +: LVL_W])
      else $error("multi-port thresholds not selected");

   a_single_levels: assert property (
      @(posedge pclk) disable iff (!presetn)
      n_act < 2'(MULTI_PORTS) |-> drop_sel == st_r.drop[LVL_SINGLE_LSB +: LVL_W]
         && pause_sel == st_r.pause[LVL_SINGLE_LSB +: LVL_W]
         && resume_sel == st_r.resume[LVL_SINGLE_LSB +: LVL_W])
      else $error("single-port thresholds not selected");

   a_count_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      cnt_clr[0] && !cnt_test_mode && !pkt_drop[0] |=> cnt_val[0] == '0)
      else $error("drop counter not cleared on read");

endmodule : pbu_admission

/* hdl/pbu_pkg.sv */
// Constants and types shared by the packet buffer unit admission block
package pbu_pkg;

   // ==========================================================
   // Geometry
   localparam int NPORT = 3;
   localparam int DATA_W = 32;
   localparam int IDX_W = 14;
   localparam int USE_W = 9;
   localparam int LVL_W = 8;

   // ==========================================================
   // Register indices, byte address is four times the index
   localparam logic [13:0] IDX_CFG = 14'h1C00;
   localparam logic [13:0] IDX_DROP = 14'h1C01;
   localparam logic [13:0] IDX_PAUSE = 14'h1C02;
   localparam logic [13:0] IDX_RESUME = 14'h1C03;
   localparam logic [13:0] IDX_CNT_BASE = 14'h1C05;
   localparam logic [13:0] IDX_STAT = 14'h1C10;

   // ==========================================================
   // Field positions
   localparam int CFG_W = 7;
   localparam int CFG_TEST_BIT = 6;
   localparam int CFG_FIXPRIO_BIT = 5;
   localparam int CFG_PACE_LSB = 2;
   localparam int CFG_YEL_BIT = 1;
   localparam int CFG_RED_BIT = 0;
   localparam int LVL_REG_W = 16;
   localparam int LVL_MULTI_LSB = 8;
   localparam int LVL_SINGLE_LSB = 0;
   localparam int STAT_ACT_LSB = 0;
   localparam int STAT_PAUSED_LSB = 4;
   localparam int STAT_MULTI_BIT = 8;

   // ==========================================================
   // Reset values and counts
   localparam logic [6:0] CFG_RST = 7'h00;
   localparam logic [15:0] DROP_RST = 16'h4964;
   localparam logic [15:0] PAUSE_RST = 16'h213C;
   localparam logic [15:0] RESUME_RST = 16'h0307;
   localparam int ACTIVE_BUFS = 36;
   localparam int MULTI_PORTS = 2;
   localparam logic [31:0] CNT_TEST_VAL = 32'h07FF_FFFC;

   // ==========================================================
   // Register selection
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_CFG,
      SEL_DROP,
      SEL_PAUSE,
      SEL_RESUME,
      SEL_STAT
   } pbu_sel_t;

endpackage : pbu_pkg

/* hdl/pbu_drop_cnt.sv */
// Saturating clear-on-read drop counter of one ingress port
`timescale 1ns/100ps
module pbu_drop_cnt #(
   parameter int CW = pbu_pkg::DATA_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic inc,
   input wire logic rd_clr,
   input wire logic test_mode,
   output logic [CW-1:0] count
);
   import pbu_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [CW-1:0] cnt;
   } pbu_cnt_st_t;

   pbu_cnt_st_t st_r;
   pbu_cnt_st_t st_nxt;
   logic [CW-1:0] base;

   // Refused at elaboration below 28 bits; the test load value itself needs 27
   if (CW < 28 || CW > DATA_W) begin : g_bad_cw
      $error("pbu_drop_cnt: CW out of range");
   end

   // Read load first, then the event, so a drop in the read cycle never gets lost
   always_comb begin
      st_nxt = st_r;
      base = st_r.cnt;
      if (rd_clr) begin
         base = test_mode ? CW'(CNT_TEST_VAL) : '0;
      end
      if (inc && base != {CW{1'b1}}) begin
         base = base + CW'(1);
      end
      st_nxt.cnt = base;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign count = st_r.cnt;

   a_test_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_clr && test_mode && !inc |=> count == CW'(CNT_TEST_VAL))
      else $error("test readback load wrong");

   a_cnt_sat: assert property (
      @(posedge pclk) disable iff (!presetn)
      count == {CW{1'b1}} && !rd_clr |=> $stable(count))
      else $error("drop counter left saturation");

endmodule : pbu_drop_cnt

/* hdl/pbu_port_track.sv */
// Buffer usage tracker with drop, pause and resume decisions of one port
`timescale 1ns/100ps
module pbu_port_track #(
   parameter int UW = pbu_pkg::USE_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic buf_alloc,
   input wire logic buf_free,
   input wire logic pkt_req,
   input wire logic pkt_red,
   input wire logic pkt_yel_hit,
   input wire logic red_en,
   input wire logic yel_en,
   input wire logic [pbu_pkg::LVL_W-1:0] drop_lvl,
   input wire logic [pbu_pkg::LVL_W-1:0] pause_lvl,
   input wire logic [pbu_pkg::LVL_W-1:0] resume_lvl,
   output logic active,
   output logic paused,
   output logic pause_frame,
   output logic resume_frame,
   output logic pkt_drop
);
   import pbu_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [UW-1:0] usage;
      logic active;
      logic paused;
      logic pause_frame;
      logic resume_frame;
      logic pkt_drop;
   } pbu_trk_st_t;

   pbu_trk_st_t st_r;
   pbu_trk_st_t st_nxt;
   logic over_drop;

   // Refused at elaboration: usage must reach every level value
   if (UW <= LVL_W) begin : g_bad_uw
      $error("pbu_port_track: UW must exceed level width");
   end

   // Levels and usage are both counted in 128-byte buffers
   assign over_drop = st_r.usage >= UW'(drop_lvl);

   always_comb begin
      st_nxt = st_r;
      st_nxt.pause_frame = 1'b0;
      st_nxt.resume_frame = 1'b0;
      // Usage saturates at both ends against a misbehaving allocator
      if (buf_alloc && !buf_free && st_r.usage != {UW{1'b1}}) begin
         st_nxt.usage = st_r.usage + UW'(1);
      end else if (buf_free && !buf_alloc && st_r.usage != '0) begin
         st_nxt.usage = st_r.usage - UW'(1);
      end
      st_nxt.active = st_nxt.usage >= UW'(ACTIVE_BUFS);
      // Hysteresis between pause and resume levels
      if (!st_r.paused && st_r.usage >= UW'(pause_lvl)) begin
         st_nxt.paused = 1'b1;
         st_nxt.pause_frame = 1'b1;
      end else if (st_r.paused && st_r.usage <= UW'(resume_lvl)) begin
         st_nxt.paused = 1'b0;
         st_nxt.resume_frame = 1'b1;
      end
      st_nxt.pkt_drop = pkt_req && (over_drop
         || (pkt_red && red_en)
         || (pkt_yel_hit && yel_en));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign active = st_r.active;
   assign paused = st_r.paused;
   assign pause_frame = st_r.pause_frame;
   assign resume_frame = st_r.resume_frame;
   assign pkt_drop = st_r.pkt_drop;

   // ==========================================================
   // Checks
   sequence s_pause_due;
      !paused && st_r.usage >= UW'(pause_lvl);
   endsequence

   sequence s_resume_due;
      paused && st_r.usage <= UW'(resume_lvl);
   endsequence

   a_pause_issue: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_pause_due |=> pause_frame && paused ##1 !pause_frame)
      else $error("pause frame not issued");

   a_resume_issue: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_resume_due |=> resume_frame && !paused)
      else $error("resume frame not issued");

   a_active_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      active == (st_r.usage >= UW'(ACTIVE_BUFS)))
      else $error("active flag disagrees with usage");

   a_red_drop: assert property (
      @(posedge pclk) disable iff (!presetn)
      pkt_req && pkt_red && red_en |=> pkt_drop)
      else $error("red packet not dropped");

   a_yellow_kept: assert property (
      @(posedge pclk) disable iff (!presetn)
      pkt_req && !over_drop && !(pkt_red && red_en) && !yel_en |=> !pkt_drop)
      else $error("packet dropped without cause");

endmodule : pbu_port_track

/* testbench/tb.sv */
// Self-checking bench of the packet buffer unit admission block
`timescale 1ns/100ps
module tb;
   import pbu_pkg::*;
   // ==========================================================
   // Clock, reset and design ports
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [2:0] buf_alloc = 3'h0, buf_free = 3'h0, pkt_req = 3'h0;
   logic [2:0] pkt_red = 3'h0, pkt_yel_hit = 3'h0;
   logic [2:0] pkt_drop, pause_frame, resume_frame, port_paused, egress_pace_en;
   logic fixed_prio_sel, yellow_discard_en, red_discard_en, cnt_test_mode;
   int miscompares = 0;
   int total_checks = 0;
   int pf_cnt [3] = '{0, 0, 0};
   int rf_cnt [3] = '{0, 0, 0};
   int exp_cnt [3] = '{0, 0, 0};
   logic [31:0] d, v;
   logic er;

   always #2 pclk = ~pclk;

   pbu_admission #(.AW(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .buf_alloc(buf_alloc), .buf_free(buf_free),
      .pkt_req(pkt_req), .pkt_red(pkt_red), .pkt_yel_hit(pkt_yel_hit), .pkt_drop(pkt_drop),
      .pause_frame(pause_frame), .resume_frame(resume_frame), .port_paused(port_paused),
      .fixed_prio_sel(fixed_prio_sel), .egress_pace_en(egress_pace_en),
      .yellow_discard_en(yellow_discard_en), .red_discard_en(red_discard_en),
      .cnt_test_mode(cnt_test_mode));

   // Pulses are counted so flow checks do not hang on exact cycles
   always @(posedge pclk) begin
      for (int i = 0; i < 3; i++) begin
         if (pause_frame[i] === 1'b1) pf_cnt[i]++;
         if (resume_frame[i] === 1'b1) rf_cnt[i]++;
      end
   end

   // ==========================================================
   // Helpers
   function automatic logic [15:0] ba(input logic [13:0] i);
      return {i, 2'b00};
   endfunction : ba

   // Expected admission answer from colour and the two discard enables
   function automatic logic drop_exp(input logic r, input logic y, input logic [31:0] c);
      return (r && c[0]) || (y && c[1]);
   endfunction : drop_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
      total_checks++;
      if (got !== e) begin
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, e);
         miscompares++;
      end
   endtask : chk

   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_o, output logic err_o);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0, "apb wait");
      rd_o = prdata;
      err_o = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, d, er);
      chk(d, e, "read data");
      chk({31'h0, er}, 32'h0, "read error");
   endtask : rd

   task automatic wr(input logic [15:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, d, er);
   endtask : wr

   // Buffers taken or released, one per cycle
   task automatic bufs(input int p, input int n, input logic fr);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         if (fr) buf_free <= 3'(1 << p);
         else buf_alloc <= 3'(1 << p);
      end
      @(posedge pclk);
      buf_alloc <= 3'h0;
      buf_free <= 3'h0;
      repeat (3) @(posedge pclk);
   endtask : bufs

   task automatic pkt(input int p, input logic r, input logic y, input logic e);
      @(posedge pclk);
      pkt_req <= 3'(1 << p);
      pkt_red <= r ? 3'(1 << p) : 3'h0;
      pkt_yel_hit <= y ? 3'(1 << p) : 3'h0;
      @(posedge pclk);
      pkt_req <= 3'h0;
      pkt_red <= 3'h0;
      pkt_yel_hit <= 3'h0;
      #1;
      chk({31'h0, pkt_drop[p]}, {31'h0, e}, "drop pulse");
      if (e) exp_cnt[p]++;
   endtask : pkt

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done

   // Hang guard, far beyond the fewer than one thousand cycles of the run
   initial begin
      #200000;
      miscompares++;
      test_done;
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'h27ab6ebe));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(ba(IDX_CFG), 32'h0000_0000);
      rd(ba(IDX_DROP), 32'h0000_4964);
      rd(ba(IDX_PAUSE), 32'h0000_213C);
      rd(ba(IDX_RESUME), 32'h0000_0307);
      // Configuration bits, corners then random
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 32'h0000_007F : (k == 1) ? 32'h0000_0000 : $urandom;
         wr(ba(IDX_CFG), v);
         rd(ba(IDX_CFG), v & 32'h0000_007F);
         chk({31'h0, fixed_prio_sel}, {31'h0, v[5]}, "fixed prio");
         chk({29'h0, egress_pace_en}, {29'h0, v[4:2]}, "pacing");
         chk({31'h0, yellow_discard_en}, {31'h0, v[1]}, "yellow en");
         chk({31'h0, red_discard_en}, {31'h0, v[0]}, "red en");
         chk({31'h0, cnt_test_mode}, {31'h0, v[6]}, "test mode");
      end
      wr(ba(IDX_CFG), 32'h0000_0000);
      // Level registers hold 16 bits, then back to defaults; a zero level
      // would pause idle ports and spoil the later pulse counts
      for (int k = 1; k < 4; k++) begin
         v = $urandom | 32'h0000_0101;
         wr(ba(IDX_CFG + 14'(k)), v);
         rd(ba(IDX_CFG + 14'(k)), v & 32'h0000_FFFF);
      end
      wr(ba(IDX_DROP), 32'h0000_4964);
      wr(ba(IDX_PAUSE), 32'h0000_213C);
      wr(ba(IDX_RESUME), 32'h0000_0307);
      // Unmapped and misaligned addresses are refused
      apb(1'b0, 16'h7044, 32'h0, d, er);
      chk({31'h0, er}, 32'h1, "unmapped error");
      apb(1'b0, 16'h7001, 32'h0, d, er);
      chk({31'h0, er}, 32'h1, "misaligned error");
      chk(d, 32'h0, "refused data");
      // One port alone uses the single-port set
      bufs(0, 35, 1'b0);
      rd(ba(IDX_STAT), 32'h0000_0000);
      bufs(0, 1, 1'b0);
      rd(ba(IDX_STAT), 32'h0000_0001);
      bufs(0, 23, 1'b0);
      chk(32'(pf_cnt[0]), 32'h0, "no early pause");
      bufs(0, 1, 1'b0);
      chk(32'(pf_cnt[0]), 32'h1, "pause at 60");
      chk({31'h0, port_paused[0]}, 32'h1, "paused");
      bufs(0, 39, 1'b0);
      pkt(0, 1'b0, 1'b0, 1'b0);
      bufs(0, 1, 1'b0);
      pkt(0, 1'b0, 1'b0, 1'b1);
      bufs(0, 92, 1'b1);
      chk(32'(rf_cnt[0]), 32'h0, "no early resume");
      bufs(0, 1, 1'b1);
      chk(32'(rf_cnt[0]), 32'h1, "resume at 7");
      chk({31'h0, port_paused[0]}, 32'h0, "released");
      // Two and three active ports switch to the multi-port set
      bufs(0, 73, 1'b0);
      pkt(0, 1'b0, 1'b0, 1'b0);
      bufs(1, 36, 1'b0);
      rd(ba(IDX_STAT), 32'h0000_0133);
      chk(32'(pf_cnt[1]), 32'h1, "multi pause");
      pkt(0, 1'b0, 1'b0, 1'b1);
      bufs(2, 36, 1'b0);
      bufs(0, 76, 1'b1);
      chk(32'(rf_cnt[0]), 32'h1, "multi no resume at 4");
      bufs(0, 1, 1'b1);
      chk(32'(rf_cnt[0]), 32'h2, "multi resume at 3");
      bufs(1, 36, 1'b1);
      bufs(2, 36, 1'b1);
      // Colour discards against enable bits, random ports
      for (int k = 0; k < 8; k++) begin
         v = 32'(k & 3);
         wr(ba(IDX_CFG), v);
         pkt($urandom % 3, k[2], ~k[2], drop_exp(k[2], ~k[2], v));
      end
      for (int p = 0; p < 3; p++) begin
         rd(ba(IDX_CNT_BASE + 14'(p)), 32'(exp_cnt[p]));
         rd(ba(IDX_CNT_BASE + 14'(p)), 32'h0000_0000);
      end
      // Test mode loads the counter on read, then it keeps counting
      wr(ba(IDX_CFG), 32'h0000_0041);
      rd(ba(IDX_CNT_BASE), 32'h0000_0000);
      rd(ba(IDX_CNT_BASE), CNT_TEST_VAL);
      pkt(0, 1'b1, 1'b0, 1'b1);
      rd(ba(IDX_CNT_BASE), CNT_TEST_VAL + 32'h1);
      test_done;
   end
endmodule : tb
